// *** src/lvd_pkg.sv ***
//Contract
//RULE_01: each of four lanes shifts through its own seven-bit serial-in register
//RULE_02: bit timing derived from link clock at seven times its rate; output clock produced
//RULE_03: lane data sampled at seven evenly spaced instants per link-clock period
//RULE_04: once per link period the four lane words leave as one 28-bit word
//RULE_05: data changes with output clock rise, stays valid across its falling edge
//RULE_06: shutdown low stops internal clocking and ignores the line inputs
//RULE_07: shutdown low clears all state and floats data and clock outputs
//RULE_08: three-lane use supported; fourth lane bits carry nothing meaningful then
//RULE_09: transmitter keeps mean link period between 14.7 ns and 32.3 ns; the model transmitter uses a 160 ns period
//RULE_10: after shutdown release outputs stay invalid for about one millisecond settling
//RULE_11: after shutdown assertion outputs float within 400 ns
//RULE_12: first serial bit is lane bit 0; lane n drives outputs 7n+6 to 7n
//RULE_13: outputs stay cleared and floating until bit timing is locked
package lvd_pkg;
    localparam int LANES = 4;
    localparam int BITS = 7;
    localparam int WORD_W = LANES * BITS;
    localparam int CNT_W = 8;
    localparam int ACC_W = 9;
    localparam int BITCNT_W = 3;
    localparam int SETTLE_W = 18;
    localparam int STABLE_W = 3;
    localparam int SYNC_W = 7;
    // sync vector layout
    localparam int SY_LANE0 = 0;
    localparam int SY_LINK = 4;
    localparam int SY_SDN = 5;
    localparam int SY_MODE3 = 6;
    localparam int LOCK_EDGES = 4;
    localparam int CLK_PERIOD_PS = 5000;
    // one millisecond of settling, counted in system clock cycles
    localparam int SETTLE_MS = 1;
    localparam int SETTLE_CYC = SETTLE_MS * 1000000000 / CLK_PERIOD_PS;
    localparam int DISABLE_NS = 400;
    localparam int DISABLE_CYC = DISABLE_NS * 1000 / CLK_PERIOD_PS;
    localparam logic [BITCNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [ACC_W-1:0] ACC_STEP = 9'h007;

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } lvd_sync_t;

    typedef struct packed {
        logic linkPrev;
        logic [CNT_W-1:0] perCnt;
        logic [CNT_W-1:0] period;
        logic [ACC_W-1:0] acc;
        logic [BITCNT_W-1:0] bitCnt;
        logic [LANES-1:0][BITS-1:0] shift;
        logic [STABLE_W-1:0] stableCnt;
        logic [SETTLE_W-1:0] settleCnt;
        logic locked;
        logic [CNT_W-1:0] hiCnt;
        logic [WORD_W-1:0] dataOut;
        logic pclk;
        logic oe;
    } lvd_state_t;
endpackage

// *** src/lvd_sync.sv ***
`timescale 1ns/1ps
module lvd_sync (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // pins
    input wire logic [lvd_pkg::SYNC_W-1:0] rawIn,
    output logic [lvd_pkg::SYNC_W-1:0] syncOut
);
    import lvd_pkg::*;
    lvd_sync_t st_reg;
    lvd_sync_t st_next;

    // first stage feeds only the second stage
    always_comb begin
        st_next.stage1 = rawIn;
        st_next.stage2 = st_reg.stage1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign syncOut = st_reg.stage2;
endmodule

// *** src/lvd_deser_top.sv ***
`timescale 1ns/1ps
module lvd_deser_top #(
    parameter int SETTLE_CYCLES = lvd_pkg::SETTLE_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // link side
    input wire logic link_clock_in,
    input wire logic [lvd_pkg::LANES-1:0] laneIn,
    // control pins
    input wire logic shutdown_clear_n,
    input wire logic threeLaneMode,
    // parallel side
    output logic [lvd_pkg::WORD_W-1:0] dataOut,
    output logic dataOe,
    output logic parallel_clock_out,
    output logic parallelClockOe
);
    import lvd_pkg::*;
    lvd_state_t s_reg;
    lvd_state_t s_next;
    logic [SYNC_W-1:0] syncV;
    logic linkS;
    logic sdnS;
    logic mode3S;
    logic rise;
    logic tick;
    logic load;
    logic [CNT_W-1:0] measured;
    logic [ACC_W-1:0] accSum;
    logic [WORD_W-1:0] word;
    logic periodStable;

    lvd_sync u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .rawIn({threeLaneMode, shutdown_clear_n, link_clock_in, laneIn}),
        .syncOut(syncV)
    );

    assign linkS = syncV[SY_LINK];
    assign sdnS = syncV[SY_SDN];
    assign mode3S = syncV[SY_MODE3];

    always_comb begin
        s_next = s_reg;
        rise = 1'b0;
        tick = 1'b0;
        load = 1'b0;
        measured = s_reg.perCnt + 8'h01;
        accSum = s_reg.acc + ACC_STEP;
        periodStable = 1'b0;
        // lane 0 in low bits; lane 3 dropped for three-lane transmitters
        word = s_reg.shift;                                        // RULE_12
        if (mode3S) begin
            word[WORD_W-1 -: BITS] = '0;                           // RULE_08
        end
        if (!sdnS) begin
            // everything cleared, line inputs ignored, outputs floated
            s_next = '0;                                           // RULE_06 RULE_07 RULE_11
        end else begin
            s_next.linkPrev = linkS;
            rise = linkS & ~s_reg.linkPrev;
            if (s_reg.settleCnt < SETTLE_W'(SETTLE_CYCLES)) begin
                s_next.settleCnt = s_reg.settleCnt + 18'h00001;  // RULE_10
            end
            if (rise) begin
                // measured period sets the bit spacing; start half a bit in
                periodStable = (measured <= s_reg.period + 8'h01) && (measured + 8'h01 >= s_reg.period);
                s_next.period = measured;                          // RULE_02
                s_next.perCnt = '0;
                s_next.acc = ACC_W'(measured >> 1);                // RULE_03
                s_next.bitCnt = '0;
                load = (s_reg.bitCnt == BIT_LAST) && s_reg.locked; // RULE_04
                if (!periodStable) begin
                    s_next.stableCnt = '0;
                    s_next.locked = 1'b0;
                end else if (s_reg.stableCnt != STABLE_W'(LOCK_EDGES)) begin
                    s_next.stableCnt = s_reg.stableCnt + 3'h1;
                end else if (s_reg.settleCnt >= SETTLE_W'(SETTLE_CYCLES)) begin
                    s_next.locked = 1'b1;                          // RULE_13
                end
            end else begin
                if (s_reg.perCnt != '1) begin
                    s_next.perCnt = s_reg.perCnt + 8'h01;
                end
                // capped at seven samples so a slow edge cannot overrun a frame
                if (s_reg.bitCnt != BIT_LAST) begin
                    if (accSum >= {1'b0, s_reg.period}) begin
                        tick = 1'b1;                               // RULE_03
                        s_next.acc = accSum - {1'b0, s_reg.period};
                        s_next.bitCnt = s_reg.bitCnt + 3'h1;
                    end else begin
                        s_next.acc = accSum;
                    end
                end
            end
            for (int l = 0; l < LANES; l++) begin
                if (tick) begin
                    s_next.shift[l] = {syncV[SY_LANE0 + l], s_reg.shift[l][BITS-1:1]}; // RULE_01 RULE_12
                end
            end
            // output clock rises with new data, falls half a link period later
            if (load) begin
                s_next.dataOut = word;                             // RULE_04
                s_next.pclk = 1'b1;                                // RULE_05
                s_next.hiCnt = s_reg.period >> 1;
            end else if (s_reg.pclk) begin
                if (s_reg.hiCnt <= 8'h01) begin
                    s_next.pclk = 1'b0;                            // RULE_05
                end else begin
                    s_next.hiCnt = s_reg.hiCnt - 8'h01;
                end
            end
            s_next.oe = s_next.locked;                             // RULE_13
            if (!s_next.locked) begin
                s_next.dataOut = '0;
                s_next.pclk = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign dataOut = s_reg.dataOut;
    assign dataOe = s_reg.oe;
    assign parallel_clock_out = s_reg.pclk;
    assign parallelClockOe = s_reg.oe;

    localparam int DIS_MAX = DISABLE_CYC;

    shutdown_float_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_11
        $fell(sdnS) |-> ##[1:DIS_MAX] (!dataOe && !parallelClockOe))
        else $error("outputs not floated after shutdown");

    cleared_off_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_07
        !dataOe |-> (dataOut == '0 && !parallel_clock_out))
        else $error("floated outputs not cleared");

    lock_gate_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_13
        dataOe |-> (s_reg.locked && s_reg.settleCnt >= SETTLE_W'(SETTLE_CYCLES)))
        else $error("outputs enabled before lock");

    word_load_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_04
        load && sdnS && s_next.locked |=> (dataOut == $past(word) && parallel_clock_out))
        else $error("word not loaded with clock rise");

    fall_stable_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_05
        $fell(parallel_clock_out) && dataOe |-> $stable(dataOut))
        else $error("data changed at output clock fall");

    seven_samples_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_03
        tick |-> (s_reg.bitCnt < BIT_LAST) ##1 (s_reg.bitCnt == $past(s_reg.bitCnt) + 3'h1))
        else $error("bit sample count wrong");

    three_lane_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_08
        $rose(parallel_clock_out) && $past(mode3S) |-> dataOut[WORD_W-1 -: BITS] == '0)
        else $error("unused lane not zero");

    lane_shift_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_01
        tick && sdnS |=> s_reg.shift[0][BITS-1] == $past(syncV[SY_LANE0]))
        else $error("lane bit not shifted in");

    settle_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // RULE_10
        $rose(sdnS) |-> !dataOe [*8])
        else $error("outputs valid too soon after release");
endmodule

// *** verif/lvd_tx_model.sv ***
`timescale 1ns/1ps
module lvd_tx_model (
    // link side
    output logic linkClk,
    output logic [lvd_pkg::LANES-1:0] lanes,
    // word source
    input wire logic [lvd_pkg::WORD_W-1:0] word,
    input wire logic threeLane
);
    import lvd_pkg::*;
    // steady period, so the mean never drifts
    localparam realtime PERIOD = 160.0;
    logic [WORD_W-1:0] frame;
    initial begin
        linkClk = 1'b0;
        lanes = '0;
        forever begin
            frame = word;
            for (int k = 0; k < BITS; k++) begin
                linkClk = (k < 4);
                for (int l = 0; l < LANES; l++) begin
                    lanes[l] = frame[l*BITS+k];
                end
                // unused lane carries junk, not the word
                if (threeLane) begin
                    lanes[LANES-1] = k[0];
                end
                #(PERIOD/BITS);
            end
        end
    end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import lvd_pkg::*;
    localparam int SETTLE = 50;
    typedef struct packed {
        logic mode;
        logic [WORD_W-1:0] word;
        logic [WORD_W-1:0] exp;
    } lvd_row_t;
    logic clk, arst_n, sdn_n, mode3, linkClk, pclk, dataOe, pclkOe;
    logic [LANES-1:0] lanes;
    logic [WORD_W-1:0] word, dataOut;
    int err_count = 0;
    int num_checks = 0;
    lvd_row_t rows [6] = '{
        '{1'b0, 28'h0000001, 28'h0000001}, '{1'b0, 28'h8000000, 28'h8000000},
        '{1'b0, 28'h5a5a5a5, 28'h5a5a5a5}, '{1'b0, 28'hfffffff, 28'hfffffff},
        '{1'b1, 28'hfffffff, 28'h01fffff}, '{1'b1, 28'h2468ace, 28'h0068ace}};
    lvd_tx_model tx_u (.linkClk(linkClk), .lanes(lanes), .word(word), .threeLane(mode3));
    lvd_deser_top #(.SETTLE_CYCLES(SETTLE)) dut_u (.clk(clk), .arst_n(arst_n), .link_clock_in(linkClk),
        .laneIn(lanes), .shutdown_clear_n(sdn_n), .threeLaneMode(mode3), .dataOut(dataOut),
        .dataOe(dataOe), .parallel_clock_out(pclk), .parallelClockOe(pclkOe));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // bounded wait for a level on the output clock
    task automatic wait_pclk(input logic v);
        int n;
        n = 0;
        while (pclk !== v && n < 400) begin
            @(negedge clk);
            n++;
        end
        check({27'h0, pclk}, {27'h0, v});
    endtask
    task automatic send(input logic m, input logic [WORD_W-1:0] w, input logic [WORD_W-1:0] e);
        mode3 = m;
        word = w;
        repeat (100) @(negedge clk);
        wait_pclk(1'b0);
        wait_pclk(1'b1);
        check(dataOut, e);
        check({26'h0, dataOe, pclkOe}, 28'h3);
        wait_pclk(1'b0);
        check(dataOut, e);
    endtask
    task automatic end_sim();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        #50000;
        err_count++;
        end_sim();
    end
    initial begin
        arst_n = 1'b0;
        sdn_n = 1'b1;
        mode3 = 1'b0;
        word = '0;
        repeat (20) @(negedge clk);
        check(dataOut, '0);
        check({26'h0, dataOe, pclkOe}, 28'h0);
        arst_n = 1'b1;
        repeat (SETTLE - 10) @(negedge clk);
        check({26'h0, dataOe, pclkOe}, 28'h0);
        foreach (rows[i]) begin
            send(rows[i].mode, rows[i].word, rows[i].exp);
        end
        // shutdown while the link keeps toggling
        sdn_n = 1'b0;
        repeat (DISABLE_CYC) @(negedge clk);
        check({26'h0, dataOe, pclkOe}, 28'h0);
        check({27'h0, pclk}, 28'h0);
        check(dataOut, '0);
        sdn_n = 1'b1;
        repeat (SETTLE - 10) @(negedge clk);
        check({26'h0, dataOe, pclkOe}, 28'h0);
        send(1'b0, 28'h1234567, 28'h1234567);
        // asynchronous reset in mid-run clears everything at once
        arst_n = 1'b0;
        @(negedge clk);
        check(dataOut, '0);
        check({26'h0, dataOe, pclkOe}, 28'h0);
        arst_n = 1'b1;
        repeat (SETTLE - 10) @(negedge clk);
        check({26'h0, dataOe, pclkOe}, 28'h0);
        send(1'b1, 28'h7654321, 28'h0054321);
        end_sim();
    end
endmodule
